// [fpc_xfer_compare.sv]
// Register-transfer and compare decode/execute of the floating-point coprocessor.
// Assumes a classic Wishbone master on core_clk_i and an arithmetic unit on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_xfer_compare
  import fpc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic au_req_o,
  output fpc_au_cmd_type au_cmd_o,
  input wire logic au_done_i,
  input wire logic [31:0] au_result_i,
  input wire fpc_au_exc_type au_exc_i,
  output fpc_flags_type host_flags_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fpc_state_type state_r, state_nxt;
  logic [31:0] instr_r, instr_nxt;
  logic [31:0] host_r, host_nxt;
  logic [31:0] opn_r, opn_nxt;
  logic [31:0] opm_r, opm_nxt;
  logic priv_r, priv_nxt;
  logic [31:0] result_r, result_nxt;
  logic [31:0] status_r, status_nxt;
  logic [31:0] control_r, control_nxt;
  fpc_outcome_type outcome_r, outcome_nxt;
  logic issue_r, issue_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic au_req_r, au_req_nxt;
  fpc_au_cmd_type au_cmd_r, au_cmd_nxt;

  logic bus_req;
  logic bus_wr;
  logic [31:0] byte_mask;
  logic [31:0] second_op;
  logic [31:0] const_val;
  fpc_cmp_type cmp;
  logic is_ours, is_xfer, is_cmp, is_data;
  logic [3:0] opc;
  logic [4:0] data_opc;
  logic [1:0] ef;
  fpc_rmode_type rmode;
  logic unord_trap, unimpl_hit, compat_hit, undef_hit;
  logic opn_uncommon, opm_uncommon, ieee_bounce;

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack drops the cycle after it rises
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign bus_wr = bus_req && wb_we_i;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Register writes honour byte lanes; unmapped reads return zero.
  always_comb begin
    ack_nxt = bus_req;
    rdata_nxt = 32'h0000_0000;
    host_nxt = host_r;
    opn_nxt = opn_r;
    opm_nxt = opm_r;
    priv_nxt = priv_r;
    instr_nxt = instr_r;
    issue_nxt = 1'b0;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `FPC_OFF_INSTR: rdata_nxt = instr_r;
        `FPC_OFF_HOST: rdata_nxt = host_r;
        `FPC_OFF_OPN: rdata_nxt = opn_r;
        `FPC_OFF_OPM: rdata_nxt = opm_r;
        `FPC_OFF_PRIV: rdata_nxt = {31'h0, priv_r};
        `FPC_OFF_RESULT: rdata_nxt = result_r;
        `FPC_OFF_STATUS: rdata_nxt = status_r;
        `FPC_OFF_CONTROL: rdata_nxt = control_r;
        `FPC_OFF_OUTCOME: rdata_nxt = {16'h0, outcome_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      unique case (wb_adr_i)
        // A write while an instruction runs is dropped, so the op cannot change mid-flight.
        `FPC_OFF_INSTR: begin
          if (!outcome_r.busy && !issue_r) begin
            instr_nxt = (instr_r & ~byte_mask) | (wb_dat_i & byte_mask);
            issue_nxt = 1'b1;
          end
        end
        `FPC_OFF_HOST: host_nxt = (host_r & ~byte_mask) | (wb_dat_i & byte_mask);
        `FPC_OFF_OPN: opn_nxt = (opn_r & ~byte_mask) | (wb_dat_i & byte_mask);
        `FPC_OFF_OPM: opm_nxt = (opm_r & ~byte_mask) | (wb_dat_i & byte_mask);
        `FPC_OFF_PRIV: priv_nxt = wb_sel_i[0] ? wb_dat_i[0] : priv_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      host_r <= 32'h0000_0000;
      opn_r <= 32'h0000_0000;
      opm_r <= 32'h0000_0000;
      priv_r <= 1'b0;
      instr_r <= 32'h0000_0000;
      issue_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      host_r <= host_nxt;
      opn_r <= opn_nxt;
      opm_r <= opm_nxt;
      priv_r <= priv_nxt;
      instr_r <= instr_nxt;
      issue_r <= issue_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Instruction field decode
  // ----------------------------------------------------------------
  assign is_ours = (instr_r[27:24] == `FPC_CLASS_CODE) && (instr_r[11:8] == `FPC_CP_NUM);
  assign is_xfer = is_ours && instr_r[4];
  assign is_data = is_ours && !instr_r[4];
  assign opc = instr_r[23:20];
  assign data_opc = {instr_r[23:20], instr_r[15]};
  assign ef = {instr_r[19], instr_r[7]};
  assign rmode = fpc_rmode_type'(instr_r[6:5]);
  assign is_cmp = is_xfer && instr_r[23] && instr_r[20] && (instr_r[15:12] == `FPC_HOST_PC);
  assign unimpl_hit = 1'(`FPC_UNIMPL_MASK >> data_opc);
  assign compat_hit = 1'(`FPC_COMPAT_MASK >> data_opc);
  assign undef_hit = 1'(`FPC_UNDEF_MASK >> data_opc);
  assign second_op = instr_r[3] ? const_val : opm_r;

  fpc_const_rom u_const_rom (
    .sel_i(instr_r[2:0]),
    .value_o(const_val)
  );

  // Code 101 and 111 negate the second operand.
  fpc_compare u_compare (
    .a_i(opn_r),
    .b_i(second_op),
    .negate_i(instr_r[21]),
    .result_o(cmp)
  );

  // Signalling compares trap on any NaN, plain ones only on a signalling NaN.
  assign unord_trap = instr_r[22] ? cmp.any_nan : cmp.snan;

  // Uncommon operands; denormals count only while the FPC_DND_BIT status bit is clear.
  assign opn_uncommon = (opn_r[30:23] == 8'hFF) ||
                        ((opn_r[30:23] == 8'h00) && (opn_r[22:0] != 23'h0) && !status_r[`FPC_DND_BIT]);
  assign opm_uncommon = !instr_r[3] && ((opm_r[30:23] == 8'hFF) ||
                        ((opm_r[30:23] == 8'h00) && (opm_r[22:0] != 23'h0) && !status_r[`FPC_DND_BIT]));
  assign ieee_bounce = au_exc_i.invalid || au_exc_i.div_zero || au_exc_i.overflow ||
                       au_exc_i.underflow || (au_exc_i.inexact && status_r[`FPC_IXE_BIT]);

  // ----------------------------------------------------------------
  // Execute: decode one issued instruction, or finish an arithmetic one
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    result_nxt = result_r;
    status_nxt = status_r;
    control_nxt = control_r;
    outcome_nxt = outcome_r;
    au_req_nxt = 1'b0;
    au_cmd_nxt = au_cmd_r;
    unique case (state_r)
      FPC_ST_IDLE: begin
        if (issue_r) begin
          outcome_nxt = '0;
          outcome_nxt.done = 1'b1;
          au_cmd_nxt.kind = FPC_AU_NONE;
          au_cmd_nxt.opcode = data_opc;
          au_cmd_nxt.prec = fpc_prec_type'(ef);
          au_cmd_nxt.rmode = rmode;
          au_cmd_nxt.dest = instr_r[18:16];
          au_cmd_nxt.first = opn_r;
          au_cmd_nxt.second = second_op;
          if (!is_ours) begin
            outcome_nxt.undef = 1'b1;
          end else if (is_cmp) begin
            // Flags: N less, Z equal, C greater-or-equal (not less while FPC_ALTCMP_BIT is set), V unordered.
            outcome_nxt.flags.n = cmp.lt;
            outcome_nxt.flags.z = cmp.eq;
            outcome_nxt.flags.c = status_r[`FPC_ALTCMP_BIT] ? !cmp.lt : (cmp.gt || cmp.eq);
            outcome_nxt.flags.v = cmp.unord;
            outcome_nxt.bounce = unord_trap;
            outcome_nxt.rs_ieee = unord_trap;
          end else if (is_xfer) begin
            // Bit 20 set carries data towards the host, clear carries it from the host.
            outcome_nxt.to_host = instr_r[20];
            unique case (opc)
              `FPC_OPC_ITOF: begin
                if (ef == 2'h3) begin
                  outcome_nxt.undef = 1'b1;
                end else begin
                  au_cmd_nxt.kind = FPC_AU_INT_TO_FLOAT;
                  au_cmd_nxt.first = host_r;
                end
              end
              // The ef bits are reserved here and ignored; only gh steers rounding.
              `FPC_OPC_FIX: au_cmd_nxt.kind = FPC_AU_FLOAT_TO_INT;
              `FPC_OPC_WST: status_nxt = host_r;
              `FPC_OPC_RST: result_nxt = status_r;
              `FPC_OPC_WCT: begin
                if (priv_r) control_nxt = host_r;
                else outcome_nxt.undef = 1'b1;
              end
              `FPC_OPC_RCT: begin
                if (priv_r) result_nxt = control_r;
                else outcome_nxt.undef = 1'b1;
              end
              default: outcome_nxt.undef = 1'b1;
            endcase
            if (outcome_nxt.undef) outcome_nxt.to_host = 1'b0;
          end else if (undef_hit || (ef == 2'h3)) begin
            outcome_nxt.undef = 1'b1;
          end else if (unimpl_hit || compat_hit) begin
            outcome_nxt.bounce = 1'b1;
            outcome_nxt.rs_unimpl = 1'b1;
          end else if (opm_uncommon || (opn_uncommon && !instr_r[15])) begin
            outcome_nxt.bounce = 1'b1;
            outcome_nxt.rs_uncommon = 1'b1;
          end else if (is_data) begin
            au_cmd_nxt.kind = FPC_AU_DATA;
          end
          // Conversions and data operations hand over to the arithmetic unit.
          if (au_cmd_nxt.kind != FPC_AU_NONE) begin
            au_req_nxt = 1'b1;
            outcome_nxt.done = 1'b0;
            outcome_nxt.busy = 1'b1;
            state_nxt = FPC_ST_WAIT_AU;
          end
        end
      end
      FPC_ST_WAIT_AU: begin
        if (au_done_i) begin
          outcome_nxt.busy = 1'b0;
          outcome_nxt.done = 1'b1;
          outcome_nxt.rs_ieee = ieee_bounce;
          outcome_nxt.rs_rare = au_exc_i.rare;
          outcome_nxt.rs_uncommon = au_exc_i.illegal_ext;
          outcome_nxt.bounce = ieee_bounce || au_exc_i.rare || au_exc_i.illegal_ext;
          if (au_cmd_r.kind == FPC_AU_FLOAT_TO_INT && !outcome_nxt.bounce) begin
            result_nxt = au_result_i;
          end
          if (outcome_nxt.bounce) outcome_nxt.to_host = 1'b0;
          state_nxt = FPC_ST_IDLE;
        end
      end
      default: state_nxt = FPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= FPC_ST_IDLE;
      result_r <= 32'h0000_0000;
      status_r <= `FPC_STATUS_RST;
      control_r <= `FPC_CONTROL_RST;
      outcome_r <= '0;
      au_req_r <= 1'b0;
      au_cmd_r <= '0;
    end else begin
      state_r <= state_nxt;
      result_r <= result_nxt;
      status_r <= status_nxt;
      control_r <= control_nxt;
      outcome_r <= outcome_nxt;
      au_req_r <= au_req_nxt;
      au_cmd_r <= au_cmd_nxt;
    end
  end

  assign au_req_o = au_req_r;
  assign au_cmd_o = au_cmd_r;
  assign host_flags_o = outcome_r.flags;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_unord_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_cmp && cmp.unord && !status_r[`FPC_ALTCMP_BIT])
    |=> (!host_flags_o.n && !host_flags_o.c && host_flags_o.v))
    else $error("Unordered compare left N or C set.");

  a_alt_complement: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_cmp && status_r[`FPC_ALTCMP_BIT])
    |=> (host_flags_o.n != host_flags_o.c))
    else $error("Alternate compare gave N equal to C.");

  a_ctrl_priv: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_xfer && !is_cmp && !priv_r &&
     (opc == `FPC_OPC_WCT || opc == `FPC_OPC_RCT))
    |=> (outcome_r.undef && control_r == $past(control_r)))
    else $error("Control access outside supervisor was not trapped.");

  a_prec_trap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_xfer && opc == `FPC_OPC_ITOF && ef == 2'h3)
    |=> (outcome_r.undef && !au_req_o))
    else $error("Illegal precision did not trap.");

  a_cmp_nan_trap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_cmp && (instr_r[22] ? cmp.any_nan : cmp.snan))
    |=> outcome_r.bounce)
    else $error("Compare NaN exception missing.");

  a_unimpl_reject: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_data && !undef_hit && ef != 2'h3 && unimpl_hit)
    |=> (outcome_r.bounce && !au_req_o && outcome_r.rs_unimpl))
    else $error("Unimplemented operation reached the arithmetic unit.");

  a_inexact_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_WAIT_AU && au_done_i && au_exc_i == 7'b0000100 && !status_r[`FPC_IXE_BIT])
    |=> (outcome_r.done && !outcome_r.bounce))
    else $error("Masked inexact bounced.");

  a_ieee_bounce: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_WAIT_AU && au_done_i && (au_exc_i.overflow || au_exc_i.invalid))
    |=> (outcome_r.bounce ##1 !outcome_r.busy))
    else $error("IEEE exception did not bounce.");

  a_status_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_r == FPC_ST_IDLE && issue_r && is_xfer && !is_cmp && opc == `FPC_OPC_WST)
    |=> (status_r == $past(host_r) && !outcome_r.to_host))
    else $error("Status write did not load the host value.");

endmodule
`default_nettype wire

// [fpc_consts.svh]
// Constants of the coprocessor transfer and compare block: offsets, fields and reset values.
// Assumes inclusion by bare name into modules that also import fpc_pkg.
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------
`define FPC_OFF_INSTR    8'h00
`define FPC_OFF_HOST     8'h04
`define FPC_OFF_OPN      8'h08
`define FPC_OFF_OPM      8'h0C
`define FPC_OFF_PRIV     8'h10
`define FPC_OFF_RESULT   8'h14
`define FPC_OFF_STATUS   8'h18
`define FPC_OFF_CONTROL  8'h1C
`define FPC_OFF_OUTCOME  8'h20

// ----------------------------------------------------------------
// Instruction fields, status bits and codes
// ----------------------------------------------------------------
`define FPC_CLASS_CODE   4'hE
`define FPC_CP_NUM       4'h1
`define FPC_HOST_PC      4'hF
`define FPC_OPC_ITOF     4'h0
`define FPC_OPC_FIX      4'h1
`define FPC_OPC_WST      4'h2
`define FPC_OPC_RST      4'h3
`define FPC_OPC_WCT      4'h4
`define FPC_OPC_RCT      4'h5
`define FPC_ALTCMP_BIT   12
`define FPC_DND_BIT      13
`define FPC_IXE_BIT      20
`define FPC_UNIMPL_MASK  32'h0001_0280
`define FPC_COMPAT_MASK  32'h0BAA_F800
`define FPC_UNDEF_MASK   32'h5400_0000
`define FPC_STATUS_RST   32'h0000_0000
`define FPC_CONTROL_RST  32'h0000_0000

`endif

// [fpc_pkg.sv]
// Types shared by the coprocessor transfer and compare block.
// Assumes nothing beyond a SystemVerilog compiler.
package fpc_pkg;

  typedef enum logic [1:0] {FPC_ST_IDLE = 2'b01, FPC_ST_WAIT_AU = 2'b10} fpc_state_type;
  typedef enum logic [1:0] {FPC_RM_NEAREST = 2'h0, FPC_RM_PLUS_INF = 2'h1,
                            FPC_RM_MINUS_INF = 2'h2, FPC_RM_ZERO = 2'h3} fpc_rmode_type;
  typedef enum logic [1:0] {FPC_PR_SINGLE = 2'h0, FPC_PR_DOUBLE = 2'h1,
                            FPC_PR_EXTENDED = 2'h2, FPC_PR_ILLEGAL = 2'h3} fpc_prec_type;
  typedef enum logic [1:0] {FPC_AU_DATA = 2'h0, FPC_AU_INT_TO_FLOAT = 2'h1,
                            FPC_AU_FLOAT_TO_INT = 2'h2, FPC_AU_NONE = 2'h3} fpc_au_kind_type;

  typedef struct packed {
    fpc_au_kind_type kind;
    logic [4:0] opcode;
    fpc_prec_type prec;
    fpc_rmode_type rmode;
    logic [2:0] dest;
    logic [31:0] first;
    logic [31:0] second;
  } fpc_au_cmd_type;

  typedef struct packed {
    logic invalid;
    logic div_zero;
    logic overflow;
    logic underflow;
    logic inexact;
    logic rare;
    logic illegal_ext;
  } fpc_au_exc_type;

  typedef struct packed {
    logic lt;
    logic eq;
    logic gt;
    logic unord;
    logic any_nan;
    logic snan;
  } fpc_cmp_type;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } fpc_flags_type;

  typedef struct packed {
    logic rs_rare;
    logic rs_unimpl;
    logic rs_ieee;
    logic rs_uncommon;
    fpc_flags_type flags;
    logic [2:0] spare;
    logic to_host;
    logic bounce;
    logic undef;
    logic done;
    logic busy;
  } fpc_outcome_type;

endpackage

// [fpc_const_rom.sv]
// Built-in constant table of the second operand, as single-precision patterns.
// Assumes a three-bit code from the instruction, purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fpc_const_rom
  import fpc_pkg::*;
(
  input wire logic [2:0] sel_i,
  output logic [31:0] value_o
);

  // Codes 000 to 111 give 0.0, 1.0, 2.0, 3.0, 4.0, 5.0, 0.5 and 10.0.
  always_comb begin
    unique case (sel_i)
      3'h0: value_o = 32'h0000_0000;
      3'h1: value_o = 32'h3F80_0000;
      3'h2: value_o = 32'h4000_0000;
      3'h3: value_o = 32'h4040_0000;
      3'h4: value_o = 32'h4080_0000;
      3'h5: value_o = 32'h40A0_0000;
      3'h6: value_o = 32'h3F00_0000;
      3'h7: value_o = 32'h4120_0000;
    endcase
  end

endmodule
`default_nettype wire

// [fpc_compare.sv]
// Single-precision comparator with optional negation of the second operand.
// Assumes operands are stable in the cycle they are compared; no state inside.
`timescale 1ns/1ps
`default_nettype none
module fpc_compare
  import fpc_pkg::*;
(
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic negate_i,
  output fpc_cmp_type result_o
);

  logic [31:0] b_eff;
  logic a_nan;
  logic b_nan;
  logic both_zero;
  logic mag_lt;

  // Negation flips the sign only; a NaN stays a NaN either way.
  assign b_eff = {b_i[31] ^ negate_i, b_i[30:0]};
  assign a_nan = (a_i[30:23] == 8'hFF) && (a_i[22:0] != 23'h0);
  assign b_nan = (b_eff[30:23] == 8'hFF) && (b_eff[22:0] != 23'h0);
  assign both_zero = (a_i[30:0] == 31'h0) && (b_eff[30:0] == 31'h0);
  assign mag_lt = a_i[30:0] < b_eff[30:0];

  // Sign-magnitude ordering; plus and minus zero compare equal.
  always_comb begin
    result_o.any_nan = a_nan || b_nan;
    result_o.snan = (a_nan && !a_i[22]) || (b_nan && !b_eff[22]);
    result_o.unord = a_nan || b_nan;
    result_o.eq = !result_o.unord && (both_zero || (a_i == b_eff));
    if (result_o.unord || result_o.eq) begin
      result_o.lt = 1'b0;
    end else if (a_i[31] != b_eff[31]) begin
      result_o.lt = a_i[31];
    end else begin
      result_o.lt = a_i[31] ? (!mag_lt && (a_i[30:0] != b_eff[30:0])) : mag_lt;
    end
    result_o.gt = !result_o.unord && !result_o.eq && !result_o.lt;
  end

endmodule
`default_nettype wire

// [fpc_au_model.sv]
// Stand-in arithmetic unit that answers each request after lat_i + 1 idle cycles.
// Assumes one request at a time, on the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module fpc_au_model
  import fpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [3:0] lat_i,
  input wire logic [31:0] res_i,
  input wire fpc_au_exc_type exc_i,
  output logic done_o,
  output logic [31:0] result_o,
  output fpc_au_exc_type exc_o
);
  int cnt = -1;
  // Outside the done cycle the result lines toggle, so a late sample cannot pass by luck.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    result_o <= ~result_o;
    exc_o <= ~exc_o;
    if (rst_i) begin
      cnt <= -1;
      result_o <= 32'h0;
      exc_o <= '0;
    end else if (req_i) begin
      cnt <= lat_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      done_o <= 1'b1;
      result_o <= res_i;
      exc_o <= exc_i;
      cnt <= -1;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Bench: drives the block over Wishbone and checks its OUTCOME word and unit commands.
// Assumes fpc_au_model stands in for the arithmetic unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpc_pkg::*;
  localparam logic [31:0] XB = 32'hEE00_0110;
  localparam logic [31:0] KV [8] = '{32'h0000_0000, 32'h3F80_0000, 32'h4000_0000, 32'h4040_0000,
    32'h4080_0000, 32'h40A0_0000, 32'h3F00_0000, 32'h4120_0000};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] oc;
  logic [31:0] res = 32'h0;
  logic [3:0] lat = 4'h0;
  logic [1:0] p;
  logic [31:0] dat_o, au_res;
  logic ack, req, au_done;
  fpc_au_exc_type exc = '0;
  fpc_au_exc_type au_exc;
  fpc_au_cmd_type cmd;
  fpc_flags_type flags;
  int n_errors = 0;
  int total_checks = 0;
  int n_req = 0;
  int r = 0;
  int i;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (req === 1'b1) n_req++;
  fpc_xfer_compare dut (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .au_req_o(req),
    .au_cmd_o(cmd), .au_done_i(au_done), .au_result_i(au_res), .au_exc_i(au_exc), .host_flags_o(flags));
  fpc_au_model au (.clk_i(clk), .rst_i(rst), .req_i(req), .lat_i(lat), .res_i(res), .exc_i(exc),
    .done_o(au_done), .result_o(au_res), .exc_o(au_exc));
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_o;
    cyc <= 1'b0;
    @(posedge clk);
    if (n >= 40) begin
      n_errors++;
      final_report();
    end
  endtask
  // Issue, then poll until done with busy low; the extra edge lets the issue land first.
  task automatic xf(input logic [31:0] ins, input logic [31:0] h, input logic [15:0] m, input logic [15:0] e);
    int n = 0;
    wb(1'b1, 8'h04, h);
    wb(1'b1, 8'h00, ins);
    @(posedge clk);
    do begin
      wb(1'b0, 8'h20, 32'h0);
      n++;
    end while (q[1:0] !== 2'b10 && n < 40);
    oc = q;
    chk("outcome", {16'h0, oc[15:0] & m}, {16'h0, e});
    if (q[1:0] !== 2'b10) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic cmp(input logic [2:0] abc, input logic [31:0] a, input logic [31:0] b, input logic [15:0] e);
    wb(1'b1, 8'h08, a);
    wb(1'b1, 8'h0C, b);
    xf(32'hEE10_F110 | {8'h0, abc, 21'h0}, 32'h0, 16'hFF0F, e);
    chk("flags", {28'h0, flags}, {28'h0, e[11:8]});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp(3'h4, 32'h3F80_0000, 32'h4000_0000, 16'h0802);
    cmp(3'h5, 32'h3F80_0000, 32'h4000_0000, 16'h0202);
    cmp(3'h6, 32'h4000_0000, 32'h4000_0000, 16'h0602);
    cmp(3'h4, 32'h7FC0_0000, 32'h4000_0000, 16'h0102);
    cmp(3'h7, 32'h7FC0_0000, 32'h4000_0000, 16'h210A);
    cmp(3'h4, 32'h7F80_0001, 32'h4000_0000, 16'h210A);
    for (i = 6; i < 16; i += 2) xf(XB | (32'(i) << 20), 0, 16'hF01F, 16'h0006);
    for (i = 7; i < 16; i += 2) xf(XB | (32'(i) << 20), 0, 16'hF01F, 16'h0006);
    for (i = 0; i < 4; i++) begin
      p = (i == 3) ? 2'h0 : i[1:0];
      lat <= 4'(3 * i);
      r++;
      xf(XB | {12'h0, p[1], 11'h0, p[0], i[1:0], 5'h0}, 32'h7 + i, 16'hF01F, 16'h0002);
      chk("cmd", 32'({cmd.kind, cmd.prec, cmd.rmode}), 32'({FPC_AU_INT_TO_FLOAT, p, i[1:0]}));
      chk("first", cmd.first, 32'h7 + i);
    end
    xf(XB | 32'h0008_0080, 0, 16'hF01F, 16'h0006);
    res <= 32'h1234;
    xf(XB | 32'h0010_0000, 0, 16'hF01F, 16'h0012);
    r++;
    wb(1'b0, 8'h14, 32'h0);
    chk("result", q, 32'h1234);
    for (i = 0; i < 6; i++) begin
      exc <= 7'h40 >> i;
      r++;
      xf(XB | 32'h0010_0000, 0, 16'hF01F, i == 4 ? 16'h0012 : i == 5 ? 16'h800A : 16'h200A);
    end
    xf(XB | 32'h0020_0000, 32'h0010_1000, 16'hF01F, 16'h0002);
    wb(1'b0, 8'h18, 32'h0);
    chk("status", q, 32'h0010_1000);
    xf(XB | 32'h0030_0000, 0, 16'hF01F, 16'h0012);
    wb(1'b0, 8'h14, 32'h0);
    chk("status read", q, 32'h0010_1000);
    exc <= 7'h04;
    r++;
    xf(XB | 32'h0010_0000, 0, 16'hF01F, 16'h200A);
    exc <= '0;
    cmp(3'h4, 32'h7FC0_0000, 32'h4000_0000, 16'h0302);
    cmp(3'h4, 32'h4000_0000, 32'h3F80_0000, 16'h0202);
    xf(XB | 32'h0040_0000, 32'h55, 16'hF01F, 16'h0006);
    wb(1'b1, 8'h10, 32'h1);
    xf(XB | 32'h0040_0000, 32'h55, 16'hF01F, 16'h0002);
    xf(XB | 32'h0050_0000, 0, 16'hF01F, 16'h0012);
    wb(1'b0, 8'h14, 32'h0);
    chk("control", q, 32'h55);
    wb(1'b0, 8'h1C, 32'h0);
    chk("control reg", q, 32'h55);
    xf(32'hEE40_8100, 0, 16'hF01F, 16'h400A);
    xf(32'hEE80_0100, 0, 16'hF01F, 16'h400A);
    xf(32'hEE30_8100, 0, 16'hF01F, 16'h400A);
    xf(32'hEE60_0100, 0, 16'hF01F, 16'h400A);
    wb(1'b1, 8'h08, 32'h7F80_0000);
    xf(32'hEE00_0100, 0, 16'hF01F, 16'h100A);
    wb(1'b1, 8'h08, 32'h0000_0001);
    xf(32'hEE00_0100, 0, 16'hF01F, 16'h100A);
    xf(XB | 32'h0020_0000, 32'h2000, 16'hF01F, 16'h0002);
    r++;
    xf(32'hEE00_0100, 0, 16'hF01F, 16'h0002);
    for (i = 0; i < 8; i++) begin
      r++;
      xf(32'hEE00_0108 | 32'(i), 0, 16'hF01F, 16'h0002);
      chk("constant", cmd.second, KV[i]);
    end
    chk("requests", 32'(n_req), 32'(r));
    final_report();
  end
endmodule
`default_nettype wire
